// ===== hw/ctv_regs.sv
// Purpose: Trim and phase delay registers for channels two and three, and a volume register for channel three.
// Assumes: The control port issues single-cycle read and write strobes, never both at once.
// Notes:   Trim and volume leave as signed step counts for the filter and decimation datapath.
`timescale 1ns/1ps
`include "ctv_params.svh"

module ctv_regs (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Control port
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wr_data,
  output logic      [7:0]        reg_rd_data,
  output logic                   reg_rd_valid,
  // Modulator streams
  input  wire logic              mod_tick,
  input  wire logic              ch2_mod_in,
  input  wire logic              ch3_mod_in,
  output logic                   ch2_mod_out,
  output logic                   ch3_mod_out,
  // Channel three sample stream
  input  wire logic [23:0]       ch3_sample_in,
  input  wire logic              ch3_sample_in_valid,
  output logic      [23:0]       ch3_sample_out,
  output logic                   ch3_sample_out_valid,
  // Settings towards the datapath
  output logic signed [4:0]      ch2_trim_tenth_db,
  output logic signed [4:0]      ch3_trim_tenth_db,
  output logic signed [8:0]      ch3_vol_half_db,
  output logic                   ch3_mute,
  output logic      [7:0]        ch2_phase_delay_code,
  output logic      [7:0]        ch3_phase_delay_code
);

  ctv_pkg::ctv_state_t state_reg;
  ctv_pkg::ctv_state_t state_next;

  logic [3:0] ch2_gain_trim_code;
  logic [3:0] ch3_gain_trim_code;
  logic [7:0] ch3_volume_code;

  assign ch2_gain_trim_code = state_reg.ch2_gain_trim_reg[`CTV_TRIM_MSB:`CTV_TRIM_LSB];
  assign ch3_gain_trim_code = state_reg.ch3_gain_trim_reg[`CTV_TRIM_MSB:`CTV_TRIM_LSB];
  assign ch3_volume_code    = state_reg.ch3_volume_reg;

  always_comb begin
    state_next          = state_reg;
    state_next.rd_valid = 1'b0;

    // Writes to unmapped addresses are dropped without effect.
    if (reg_wr_en) begin
      case (reg_addr)
        `CTV_ADDR_CH2_GAIN_TRIM: begin
          // The reserved low nibble is never stored, so it always reads back as zero.
          state_next.ch2_gain_trim_reg = {reg_wr_data[`CTV_TRIM_MSB:`CTV_TRIM_LSB], 4'h0};
        end
        `CTV_ADDR_CH2_PHASE_DELAY: begin
          state_next.ch2_phase_delay_reg = reg_wr_data;
        end
        `CTV_ADDR_CH3_VOLUME: begin
          state_next.ch3_volume_reg = reg_wr_data;
        end
        `CTV_ADDR_CH3_GAIN_TRIM: begin
          state_next.ch3_gain_trim_reg = {reg_wr_data[`CTV_TRIM_MSB:`CTV_TRIM_LSB], 4'h0};
        end
        `CTV_ADDR_CH3_PHASE_DELAY: begin
          state_next.ch3_phase_delay_reg = reg_wr_data;
        end
        default: begin
          state_next.ch3_phase_delay_reg = state_reg.ch3_phase_delay_reg;
        end
      endcase
    end

    // Reads answer one cycle later; an unmapped address answers zero.
    if (reg_rd_en) begin
      state_next.rd_valid = 1'b1;
      case (reg_addr)
        `CTV_ADDR_CH2_GAIN_TRIM:   state_next.rd_data = state_reg.ch2_gain_trim_reg;
        `CTV_ADDR_CH2_PHASE_DELAY: state_next.rd_data = state_reg.ch2_phase_delay_reg;
        `CTV_ADDR_CH3_VOLUME:      state_next.rd_data = state_reg.ch3_volume_reg;
        `CTV_ADDR_CH3_GAIN_TRIM:   state_next.rd_data = state_reg.ch3_gain_trim_reg;
        `CTV_ADDR_CH3_PHASE_DELAY: state_next.rd_data = state_reg.ch3_phase_delay_reg;
        default:                   state_next.rd_data = 8'h00;
      endcase
    end

    // Trim is the code minus eight in tenths of a decibel: 0 is -0.8, 9 is +0.1, 15 is +0.7.
    state_next.ch2_trim_tenth_db = $signed({1'b0, ch2_gain_trim_code} - `CTV_TRIM_NEUTRAL);
    state_next.ch3_trim_tenth_db = $signed({1'b0, ch3_gain_trim_code} - `CTV_TRIM_NEUTRAL);

    // Volume is the code minus 201 in half decibels: 1 is -100, 255 is +27.
    state_next.ch3_vol_half_db = $signed({1'b0, ch3_volume_code} - `CTV_VOL_ZERO_DB_CODE);
    state_next.ch3_mute        = (ch3_volume_code == `CTV_VOL_MUTE_CODE);

    // Mute uses the stored code directly so a sample in the write cycle after is already silenced.
    state_next.ch3_sample_valid = ch3_sample_in_valid;
    if (ch3_sample_in_valid) begin
      if (ch3_volume_code == `CTV_VOL_MUTE_CODE) begin
        state_next.ch3_sample = 24'h000000;
      end else begin
        state_next.ch3_sample = ch3_sample_in;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg                     <= '0;
      state_reg.ch2_gain_trim_reg   <= `CTV_RST_GAIN_TRIM;
      state_reg.ch3_gain_trim_reg   <= `CTV_RST_GAIN_TRIM;
      state_reg.ch2_phase_delay_reg <= `CTV_RST_PHASE_DELAY;
      state_reg.ch3_phase_delay_reg <= `CTV_RST_PHASE_DELAY;
      state_reg.ch3_volume_reg      <= `CTV_RST_VOLUME;
    end else begin
      state_reg <= state_next;
    end
  end

  // Each channel gets its own delay line driven from its phase delay code.
  ctv_delay_line u_ch2_delay (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .mod_tick   (mod_tick),
    .bit_in     (ch2_mod_in),
    .delay_code (state_reg.ch2_phase_delay_reg),
    .bit_out    (ch2_mod_out)
  );

  ctv_delay_line u_ch3_delay (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .mod_tick   (mod_tick),
    .bit_in     (ch3_mod_in),
    .delay_code (state_reg.ch3_phase_delay_reg),
    .bit_out    (ch3_mod_out)
  );

  assign reg_rd_data          = state_reg.rd_data;
  assign reg_rd_valid         = state_reg.rd_valid;
  assign ch3_sample_out       = state_reg.ch3_sample;
  assign ch3_sample_out_valid = state_reg.ch3_sample_valid;
  assign ch2_trim_tenth_db    = state_reg.ch2_trim_tenth_db;
  assign ch3_trim_tenth_db    = state_reg.ch3_trim_tenth_db;
  assign ch3_vol_half_db      = state_reg.ch3_vol_half_db;
  assign ch3_mute             = state_reg.ch3_mute;
  assign ch2_phase_delay_code = state_reg.ch2_phase_delay_reg;
  assign ch3_phase_delay_code = state_reg.ch3_phase_delay_reg;

endmodule

// ===== hw/ctv_params.svh
// Purpose: Constants for the channel trim and volume register bank.
// Assumes: Eight-bit register addresses and eight-bit register data.
// Notes:   Types live in ctv_pkg; this header carries numbers only.
`ifndef CTV_PARAMS_SVH
`define CTV_PARAMS_SVH

// Register addresses.
`define CTV_ADDR_CH2_GAIN_TRIM   8'h44
`define CTV_ADDR_CH2_PHASE_DELAY 8'h45
`define CTV_ADDR_CH3_VOLUME      8'h48
`define CTV_ADDR_CH3_GAIN_TRIM   8'h49
`define CTV_ADDR_CH3_PHASE_DELAY 8'h4A

// Reset values.
`define CTV_RST_GAIN_TRIM        8'h80
`define CTV_RST_PHASE_DELAY      8'h00
`define CTV_RST_VOLUME           8'hC9

// Gain trim field position and its neutral code.
`define CTV_TRIM_MSB             7
`define CTV_TRIM_LSB             4
`define CTV_TRIM_NEUTRAL         5'h08

// Volume codes.
`define CTV_VOL_MUTE_CODE        8'h00
`define CTV_VOL_ZERO_DB_CODE     9'h0C9

// Deepest delay in modulator clock cycles.
`define CTV_DELAY_MAX            255

`endif

// ===== hw/ctv_pkg.sv
// Purpose: Types for the channel trim and volume register bank.
// Assumes: Constants come from ctv_params.svh.
// Notes:   One packed struct holds all state of each module.
package ctv_pkg;

  typedef struct packed {
    logic [7:0]        ch2_gain_trim_reg;
    logic [7:0]        ch2_phase_delay_reg;
    logic [7:0]        ch3_volume_reg;
    logic [7:0]        ch3_gain_trim_reg;
    logic [7:0]        ch3_phase_delay_reg;
    logic [7:0]        rd_data;
    logic              rd_valid;
    logic signed [4:0] ch2_trim_tenth_db;
    logic signed [4:0] ch3_trim_tenth_db;
    logic signed [8:0] ch3_vol_half_db;
    logic              ch3_mute;
    logic [23:0]       ch3_sample;
    logic              ch3_sample_valid;
  } ctv_state_t;

  typedef struct packed {
    logic [254:0] taps;
  } ctv_delay_state_t;

endpackage

// ===== hw/ctv_delay_line.sv
// Purpose: Delays one modulator bit stream by a programmable count of modulator cycles.
// Assumes: mod_tick is a one-cycle pulse per modulator clock cycle, synchronous to sys_clk.
// Notes:   The tap is chosen combinationally so a code of zero passes the input straight on.
`timescale 1ns/1ps
`include "ctv_params.svh"

module ctv_delay_line (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Modulator stream
  input  wire logic       mod_tick,
  input  wire logic       bit_in,
  // Delay setting
  input  wire logic [7:0] delay_code,
  // Delayed stream
  output logic            bit_out
);

  ctv_pkg::ctv_delay_state_t state_reg;
  ctv_pkg::ctv_delay_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (mod_tick) begin
      state_next.taps = {state_reg.taps[`CTV_DELAY_MAX-2:0], bit_in};
    end
  end

  // Tap N-1 of the chain holds the bit taken N ticks earlier.
  always_comb begin
    if (delay_code == 8'h00) begin
      bit_out = bit_in;
    end else begin
      bit_out = state_reg.taps[delay_code - 8'h01];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// ===== dv/ctv_regs_assertions.sv
// Purpose: Port checks for ctv_regs.
// Assumes: Sees only the top ports.
// Notes:   Derived outputs lag a write by two edges.
`timescale 1ns/1ps
module ctv_regs_chk (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              reg_wr_en,
  input wire logic              reg_rd_en,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wr_data,
  input wire logic [7:0]        reg_rd_data,
  input wire logic              reg_rd_valid,
  input wire logic              mod_tick,
  input wire logic              ch2_mod_in,
  input wire logic              ch2_mod_out,
  input wire logic              ch3_sample_in_valid,
  input wire logic              ch3_sample_out_valid,
  input wire logic signed [4:0] ch3_trim_tenth_db,
  input wire logic signed [8:0] ch3_vol_half_db,
  input wire logic              ch3_mute,
  input wire logic [7:0]        ch2_phase_delay_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid) else $error("read answer missing");
  rd_pulse_a: assert property (!reg_rd_en |=> !reg_rd_valid) else $error("read answer without request");
  rsv_zero_a: assert property (reg_rd_en && (reg_addr == 8'h44 || reg_addr == 8'h49) |=>
    reg_rd_data[3:0] == 4'h0) else $error("reserved bits not zero");
  phase_rst_a: assert property ($fell(rst) |-> ch2_phase_delay_code == 8'h00) else $error("phase reset");
  pass_zero_a: assert property (ch2_phase_delay_code == 8'h00 |-> ch2_mod_out == ch2_mod_in)
    else $error("zero delay not direct");
  delay_one_a: assert property (mod_tick ##1 ch2_phase_delay_code == 8'h01 |-> ch2_mod_out == $past(ch2_mod_in))
    else $error("one cycle delay wrong");
  trim_step_a: assert property (reg_wr_en && !reg_rd_en && reg_addr == 8'h49 |-> ##2
    ch3_trim_tenth_db == $signed({1'b0, $past(reg_wr_data[7:4], 2)}) - 5'sh08) else $error("trim step wrong");
  vol_step_a: assert property (reg_wr_en && !reg_rd_en && reg_addr == 8'h48 && reg_wr_data != 8'h00 |-> ##2
    ch3_vol_half_db == $signed({1'b0, $past(reg_wr_data, 2)}) - 9'sh0C9) else $error("volume step wrong");
  mute_set_a: assert property (reg_wr_en && !reg_rd_en && reg_addr == 8'h48 |-> ##2
    ch3_mute == ($past(reg_wr_data, 2) == 8'h00)) else $error("mute wrong");
  smp_valid_a: assert property (ch3_sample_in_valid |=> ch3_sample_out_valid) else $error("sample lost");
endmodule
bind ctv_regs ctv_regs_chk chk (.sys_clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
  .reg_rd_valid, .mod_tick, .ch2_mod_in, .ch2_mod_out, .ch3_sample_in_valid, .ch3_sample_out_valid,
  .ch3_trim_tenth_db, .ch3_vol_half_db, .ch3_mute, .ch2_phase_delay_code);

// ===== dv/testbench.sv
// Purpose: Self-checking bench for ctv_regs.
// Assumes: Strobes are one-cycle pulses.
// Notes:   Software keeps the reserved trim bits at zero, so writes carry zero there.
`timescale 1ns/1ps
module testbench;
  logic              sys_clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [7:0]        reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data, ch2_phase_delay_code, ch3_phase_delay_code;
  logic              reg_rd_valid, mod_tick = 1'b0, ch2_mod_in = 1'b0, ch3_mod_in = 1'b0, ch2_mod_out, ch3_mod_out;
  logic [23:0]       ch3_sample_in = 24'h000000, ch3_sample_out;
  logic              ch3_sample_in_valid = 1'b0, ch3_sample_out_valid, ch3_mute;
  logic signed [4:0] ch2_trim_tenth_db, ch3_trim_tenth_db;
  logic signed [8:0] ch3_vol_half_db;
  logic              h [300];
  logic [7:0]        vols [5] = '{8'h00, 8'h01, 8'h02, 8'hC9, 8'hFF};
  int                errors = 0, total_checks = 0, cycles = 0;
  ctv_regs dut (.sys_clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid,
    .mod_tick, .ch2_mod_in, .ch3_mod_in, .ch2_mod_out, .ch3_mod_out, .ch3_sample_in, .ch3_sample_in_valid,
    .ch3_sample_out, .ch3_sample_out_valid, .ch2_trim_tenth_db, .ch3_trim_tenth_db, .ch3_vol_half_db,
    .ch3_mute, .ch2_phase_delay_code, .ch3_phase_delay_code);
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk({23'h0, reg_rd_valid}, 24'h000001);
    chk({16'h0, reg_rd_data}, {16'h0, e});
  endtask
  task automatic smp(input logic [23:0] d, input logic [23:0] e);
    @(posedge sys_clk);
    ch3_sample_in_valid <= 1'b1;
    ch3_sample_in <= d;
    @(posedge sys_clk);
    ch3_sample_in_valid <= 1'b0;
    #1;
    chk({23'h0, ch3_sample_out_valid}, 24'h000001);
    chk(ch3_sample_out, e);
  endtask
  // Timeout: the whole test needs well under a thousand cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h44, 8'h80);
    rd(8'h45, 8'h00);
    rd(8'h48, 8'hC9);
    rd(8'h49, 8'h80);
    rd(8'h4A, 8'h00);
    rd(8'h46, 8'h00);
    chk({16'h0, ch2_phase_delay_code}, 24'h000000);
    chk({16'h0, ch3_phase_delay_code}, 24'h000000);
    chk({15'h0, ch3_vol_half_db}, 24'h000000);
    for (int c = 0; c < 16; c++) begin
      wr(8'h44, {c[3:0], 4'h0});
      wr(8'h49, {c[3:0], 4'h0});
      rd(8'h44, {c[3:0], 4'h0});
      rd(8'h49, {c[3:0], 4'h0});
      chk({19'h0, ch2_trim_tenth_db}, {19'h0, 5'(c - 8)});
      chk({19'h0, ch3_trim_tenth_db}, {19'h0, 5'(c - 8)});
    end
    foreach (vols[i]) begin
      wr(8'h48, vols[i]);
      rd(8'h48, vols[i]);
      chk({23'h0, ch3_mute}, {23'h0, vols[i] == 8'h00});
      if (vols[i] != 8'h00) chk({15'h0, ch3_vol_half_db}, {15'h0, 9'({1'b0, vols[i]} - 9'h0C9)});
      smp(24'h5A5A5A, (vols[i] == 8'h00) ? 24'h000000 : 24'h5A5A5A);
    end
    wr(8'h45, 8'h01);
    wr(8'h4A, 8'hFF);
    wr(8'h46, 8'hFF);
    rd(8'h4A, 8'hFF);
    rd(8'h46, 8'h00);
    chk({16'h0, ch2_phase_delay_code}, 24'h000001);
    chk({16'h0, ch3_phase_delay_code}, 24'h0000FF);
    for (int i = 0; i < 300; i++) begin
      h[i] = ^(i[8:0] & 9'h025);
      @(posedge sys_clk);
      mod_tick <= 1'b1;
      ch2_mod_in <= h[i];
      ch3_mod_in <= ~h[i];
      #1;
      if (i >= 1) chk({23'h0, ch2_mod_out}, {23'h0, h[i - 1]});
      if (i >= 255) chk({23'h0, ch3_mod_out}, {23'h0, ~h[i - 255]});
    end
    stop_test();
  end
endmodule
